// ### acb_reg_bank.sv
/*
 * configuration register bank of a dual-channel sampling converter:
 * 16-bit registers in two banks, read/write except status, with decoded control outputs
 * for power, reference, data rate, lanes, xor output and the mixer.
 * assumes a single-cycle register port synchronous to i_core_clk, and
 * that the converter core reads the control outputs as levels.
 */
`timescale 1ns/1ps
`include "acb_consts.svh"

module acb_reg_bank
    import acb_pkg::*;
#(
    parameter int NUM_REGS = 17
)
(
    input  wire logic        i_core_clk,
    input  wire logic        i_arst_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire logic        i_conv_a_valid,
    input  wire logic        i_conv_b_valid,
    output logic             o_conv_a_valid,
    output logic             o_conv_b_valid,
    output logic             o_adc_a_pd,
    output logic             o_adc_b_pd,
    output logic             o_chip_pd,
    output logic             o_int_ref_en,
    output logic             o_sdr_mode,
    output logic      [2:0]  o_averaging_output_clock_cfg,
    output logic      [1:0]  o_lane_count,
    output logic             o_lane_24bit,
    output logic             o_lane_clock_sel_a,
    output logic             o_lane_clock_sel_b,
    output logic             o_lane_clock_sel_c,
    output logic      [1:0]  o_low_rate_variant_clock,
    output logic             o_high_rate_variant_clock,
    output logic             o_avg_enabled,
    output logic             o_init_active,
    output logic             o_xor_en,
    output logic             o_xor_with_lsb,
    output logic             o_oscillator_sync_mode,
    output logic             o_downconverter_enable,
    output logic      [23:0] o_oscillator_phase_word,
    output logic      [23:0] o_oscillator_frequency_word
);

    ////////////////////////////////////////////////////////////////////////
    // reset synchroniser
    logic rst_meta_q;
    logic rst_n_q;

    // release is synchronised, assertion stays asynchronous
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode
    localparam int IX_LAP = 0;
    localparam int IX_RR  = 1;
    localparam int IX_ACP = 2;
    localparam int IX_LCE = 3;
    localparam int IX_SA  = 4;
    localparam int IX_SB  = 5;
    localparam int IX_DDC = 6;
    localparam int IX_PL  = 7;
    localparam int IX_PFM = 8;
    localparam int IX_FH  = 9;
    localparam int IX_B2E = 10;
    localparam int IX_B2C = 11;
    localparam int IX_B2D = 12;
    localparam int IX_B2L = 13;
    localparam int IX_BSL = 14;
    localparam int IX_LAN = 15;
    localparam int IX_STA = 16;

    acb_word_t regs_q [NUM_REGS];
    logic      bank2_sel;

    // map an address to a register index; bank 2 offsets need bank select
    function automatic logic [5:0] reg_index(input acb_addr_t a, input logic b2);
        logic [5:0] ix;
        ix = 6'h3F;
        if (a == `ACB_OFF_BANK_SEL)            ix = 6'(IX_BSL);
        else if (a == `ACB_OFF_LANE_CFG)       ix = 6'(IX_LAN);
        else if (a == `ACB_OFF_STATUS)         ix = 6'(IX_STA);
        else if (b2)
        begin
            case (a)
                `ACB_OFF_B2_STARTUP_E: ix = 6'(IX_B2E);
                `ACB_OFF_B2_STARTUP_C: ix = 6'(IX_B2C);
                `ACB_OFF_B2_STARTUP_D: ix = 6'(IX_B2D);
                `ACB_OFF_B2_LOW_CLK:   ix = 6'(IX_B2L);
                default:               ix = 6'h3F;
            endcase
        end
        else
        begin
            case (a)
                `ACB_OFF_LANE_AVG_PWR:   ix = 6'(IX_LAP);
                `ACB_OFF_REF_RATE:       ix = 6'(IX_RR);
                `ACB_OFF_AVG_CHIP_PWR:   ix = 6'(IX_ACP);
                `ACB_OFF_LANE_CLK_EXTRA: ix = 6'(IX_LCE);
                `ACB_OFF_STARTUP_A:      ix = 6'(IX_SA);
                `ACB_OFF_STARTUP_B:      ix = 6'(IX_SB);
                `ACB_OFF_DDC_CTRL:       ix = 6'(IX_DDC);
                `ACB_OFF_OSC_PH_LO:      ix = 6'(IX_PL);
                `ACB_OFF_OSC_MID:        ix = 6'(IX_PFM);
                `ACB_OFF_OSC_FR_HI:      ix = 6'(IX_FH);
                default:                 ix = 6'h3F;
            endcase
        end
        return ix;
    endfunction

    wire logic [5:0] wr_ix  = reg_index(i_addr, bank2_sel);
    wire logic [5:0] rd_ix  = reg_index(i_addr, bank2_sel);
    wire logic       rd_hit = (rd_ix < 6'(NUM_REGS));
    assign bank2_sel = regs_q[IX_BSL][0];

    ////////////////////////////////////////////////////////////////////////
    // storage; status is read-only and ignores writes
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++)
        begin : g_reg
            if (g == IX_STA)
            begin : g_ro
                always_ff @(posedge i_core_clk or negedge rst_n_q)
                begin
                    if (!rst_n_q)
                        regs_q[g] <= `ACB_RST_VAL;
                    else
                        regs_q[g] <= {11'h000, o_init_active, o_avg_enabled, o_chip_pd,
                                      o_adc_b_pd, o_adc_a_pd};
                end
            end
            else
            begin : g_rw
                // new value takes effect the edge after the write
                always_ff @(posedge i_core_clk or negedge rst_n_q)
                begin
                    if (!rst_n_q)
                        regs_q[g] <= `ACB_RST_VAL;
                    else if (i_wr && wr_ix == 6'(g))
                        regs_q[g] <= i_wdata;
                end
            end
        end
    endgenerate

    // read data valid only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            o_rdata <= `ACB_RST_VAL;
        else if (i_rd && rd_hit)
            o_rdata <= regs_q[rd_ix[4:0]];
        else
            o_rdata <= `ACB_RST_VAL;
    end

    ////////////////////////////////////////////////////////////////////////
    // field decode
    wire logic [1:0] chpd = regs_q[IX_LAP][`ACB_CHPD_LSB +: 2];
    wire logic [1:0] avg_a = regs_q[IX_LAP][`ACB_AVG_A_LSB +: 2];
    wire logic [1:0] avg_b = regs_q[IX_ACP][`ACB_AVG_B_LSB +: 2];
    wire logic       avg_c = regs_q[IX_ACP][`ACB_AVG_C_BIT];
    wire logic [2:0] lane  = regs_q[IX_LAN][`ACB_LANE_LSB +: 3];

    // channel power-down decode
    assign o_adc_a_pd = (chpd == `ACB_CHPD_A) || (chpd == `ACB_CHPD_BOTH) || o_chip_pd;
    assign o_adc_b_pd = (chpd == `ACB_CHPD_B) || (chpd == `ACB_CHPD_BOTH) || o_chip_pd;
    assign o_chip_pd  = regs_q[IX_ACP][`ACB_CHIP_PD_BIT];

    // gate results of a stopped channel; chip power-down stops both
    assign o_conv_a_valid = i_conv_a_valid && !o_adc_a_pd;
    assign o_conv_b_valid = i_conv_b_valid && !o_adc_b_pd;

    assign o_int_ref_en = !regs_q[IX_RR][`ACB_REF_SEL_BIT];
    assign o_sdr_mode   = regs_q[IX_RR][`ACB_RATE_BIT];
    assign o_averaging_output_clock_cfg = regs_q[IX_LAP][`ACB_AVG_CLK_LSB +: 3];

    // lane layout: low bit clear gives two lanes, only settings 010 and 111 give 24 bits
    assign o_lane_count = (lane == ACB_LANE_ONE_20 || lane == ACB_LANE_ONE_24) ? 2'h1 : 2'h2;
    assign o_lane_24bit = (lane == ACB_LANE_SEP_24 || lane == ACB_LANE_ONE_24);

    // clock configuration bits are passed on as written
    assign o_lane_clock_sel_a        = regs_q[IX_LAP][`ACB_LANE_CLK_A_BIT];
    assign o_lane_clock_sel_b        = regs_q[IX_RR][`ACB_LANE_CLK_B_BIT];
    assign o_lane_clock_sel_c        = regs_q[IX_LCE][`ACB_LANE_CLK_C_BIT];
    assign o_low_rate_variant_clock  = regs_q[IX_LCE][`ACB_LOW_CLK_LSB +: 2];
    assign o_high_rate_variant_clock = regs_q[IX_DDC][`ACB_HI_CLK_BIT];

    // averaging active only for the full 1,2,1 setup
    assign o_avg_enabled = (avg_a == `ACB_AVG_A_ON) && (avg_b == `ACB_AVG_B_ON) && avg_c;

    // startup sequence seen as open when bit 1 of startup A or B, or any bit of a bank 2 startup register, is set
    assign o_init_active = regs_q[IX_SA][`ACB_INIT_A_BIT] | regs_q[IX_SB][`ACB_INIT_B_BIT]
                         | (|regs_q[IX_B2C]) | (|regs_q[IX_B2D]) | (|regs_q[IX_B2E]);

    // xor output: enable in lane register, source in mixer control
    assign o_xor_en       = regs_q[IX_LAN][`ACB_XOR_EN_BIT];
    assign o_xor_with_lsb = regs_q[IX_DDC][`ACB_XOR_SRC_BIT];

    assign o_oscillator_sync_mode = regs_q[IX_DDC][`ACB_SYNC_MODE_BIT];
    assign o_downconverter_enable = regs_q[IX_DDC][`ACB_DDC_EN_BIT];

    // oscillator words assembled across register boundaries
    assign o_oscillator_phase_word     = {regs_q[IX_PFM][`ACB_BYTE_HI_LSB-1:0], regs_q[IX_PL]};
    assign o_oscillator_frequency_word = {regs_q[IX_FH], regs_q[IX_PFM][15:`ACB_BYTE_HI_LSB]};

endmodule

// ### acb_consts.svh
/*
 * constants for the converter configuration register bank: offsets,
 * field positions, encodings and reset values.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef ACB_CONSTS_SVH
`define ACB_CONSTS_SVH

// register offsets, bank 1 (main map)
`define ACB_OFF_LANE_AVG_PWR   8'hC0
`define ACB_OFF_REF_RATE       8'hC1
`define ACB_OFF_AVG_CHIP_PWR   8'hC4
`define ACB_OFF_LANE_CLK_EXTRA 8'hC5
`define ACB_OFF_STARTUP_A      8'hF4
`define ACB_OFF_STARTUP_B      8'hF6
`define ACB_OFF_DDC_CTRL       8'hFB
`define ACB_OFF_OSC_PH_LO      8'hFC
`define ACB_OFF_OSC_MID        8'hFD
`define ACB_OFF_OSC_FR_HI      8'hFE
// register offsets, bank 2
`define ACB_OFF_B2_STARTUP_E   8'h0A
`define ACB_OFF_B2_STARTUP_C   8'h12
`define ACB_OFF_B2_STARTUP_D   8'h13
`define ACB_OFF_B2_LOW_CLK     8'h1C
// bank select, lane setting and status (own map, decoded in either bank)
`define ACB_OFF_BANK_SEL       8'h00
`define ACB_OFF_LANE_CFG       8'h01
`define ACB_OFF_STATUS         8'h02

`define ACB_RST_VAL            16'h0000

// field positions
`define ACB_CHPD_LSB           0
`define ACB_AVG_CLK_LSB        7
`define ACB_AVG_A_LSB          10
`define ACB_LANE_CLK_A_BIT     12
`define ACB_REF_SEL_BIT        11
`define ACB_RATE_BIT           8
`define ACB_LANE_CLK_B_BIT     0
`define ACB_AVG_B_LSB          4
`define ACB_AVG_C_BIT          1
`define ACB_CHIP_PD_BIT        0
`define ACB_LANE_CLK_C_BIT     9
`define ACB_LOW_CLK_LSB        2
`define ACB_INIT_A_BIT         1
`define ACB_INIT_B_BIT         1
`define ACB_SYNC_MODE_BIT      3
`define ACB_XOR_SRC_BIT        2
`define ACB_HI_CLK_BIT         1
`define ACB_DDC_EN_BIT         0
`define ACB_BYTE_HI_LSB        8
`define ACB_LANE_LSB           0
`define ACB_XOR_EN_BIT         3

// averaging setup values that together switch averaging on
`define ACB_AVG_A_ON           2'h1
`define ACB_AVG_B_ON           2'h2

// channel power-down encodings
`define ACB_CHPD_NONE          2'h0
`define ACB_CHPD_A             2'h1
`define ACB_CHPD_B             2'h2
`define ACB_CHPD_BOTH          2'h3

`endif

// ### acb_pkg.sv
/*
 * types for the converter configuration register bank.
 * assumes acb_consts.svh is on the include path.
 */
package acb_pkg;
    `include "acb_consts.svh"

    typedef logic [15:0] acb_word_t;
    typedef logic [7:0]  acb_addr_t;

    // output lane layout chosen by the lane setting
    typedef enum logic [2:0]
    {
        ACB_LANE_SEP_20  = 3'b000,
        ACB_LANE_SEP_24  = 3'b010,
        ACB_LANE_ONE_20  = 3'b101,
        ACB_LANE_ONE_24  = 3'b111
    } acb_lane_e;
endpackage

// ### acb_reg_bank_props.sv
/*
 * concurrent checks on the ports of the converter configuration register bank.
 * assumes binding to acb_reg_bank, one clock, i_arst_n active low.
 */
`timescale 1ns/1ps
`include "acb_consts.svh"

module acb_reg_bank_props
(
    input wire logic        i_core_clk,
    input wire logic        i_arst_n,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        i_conv_a_valid,
    input wire logic        i_conv_b_valid,
    input wire logic        o_conv_a_valid,
    input wire logic        o_conv_b_valid,
    input wire logic        o_adc_a_pd,
    input wire logic        o_adc_b_pd,
    input wire logic        o_chip_pd,
    input wire logic        o_int_ref_en,
    input wire logic        o_sdr_mode,
    input wire logic        o_xor_with_lsb,
    input wire logic        o_oscillator_sync_mode,
    input wire logic        o_downconverter_enable,
    input wire logic [23:0] o_oscillator_phase_word,
    input wire logic [23:0] o_oscillator_frequency_word
);
    ////////////////////////////////////////////////////////////////////////////
    // own copy of the bank select, so main-map writes are recognised
    logic bank_q;
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            bank_q <= 1'b0;
        else if (i_wr && i_addr == `ACB_OFF_BANK_SEL)
            bank_q <= i_wdata[0];
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    // a write to one main-map offset
    sequence s_wr(logic [7:0] a);
        i_wr && !bank_q && i_addr == a;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    a_chpd_decode: assert property (s_wr(`ACB_OFF_LANE_AVG_PWR) |=>
        o_adc_a_pd == ($past(i_wdata[0]) || o_chip_pd) && o_adc_b_pd == ($past(i_wdata[1]) || o_chip_pd))
        else $error("channel power-down decode wrong");
    a_chip_pd_set: assert property (s_wr(`ACB_OFF_AVG_CHIP_PWR) |=>
        o_chip_pd == $past(i_wdata[0]) && (!o_chip_pd || (o_adc_a_pd && o_adc_b_pd)))
        else $error("chip power-down not applied");
    a_ref_rate: assert property (s_wr(`ACB_OFF_REF_RATE) |=>
        o_int_ref_en == !$past(i_wdata[11]) && o_sdr_mode == $past(i_wdata[8]))
        else $error("reference or rate select wrong");
    a_ddc_fields: assert property (s_wr(`ACB_OFF_DDC_CTRL) |=> o_downconverter_enable == $past(i_wdata[0])
        && o_xor_with_lsb == $past(i_wdata[2]) && o_oscillator_sync_mode == $past(i_wdata[3]))
        else $error("mixer control fields wrong");
    a_phase_low: assert property (s_wr(`ACB_OFF_OSC_PH_LO) |=>
        o_oscillator_phase_word[15:0] == $past(i_wdata))
        else $error("phase word low part wrong");
    a_mid_split: assert property (s_wr(`ACB_OFF_OSC_MID) |=>
        o_oscillator_phase_word[23:16] == $past(i_wdata[7:0]) && o_oscillator_frequency_word[7:0] == $past(i_wdata[15:8]))
        else $error("middle oscillator register split wrong");
    a_freq_high: assert property (s_wr(`ACB_OFF_OSC_FR_HI) |=>
        o_oscillator_frequency_word[23:8] == $past(i_wdata))
        else $error("frequency word high part wrong");
    a_conv_gate: assert property (o_conv_a_valid == (i_conv_a_valid && !o_adc_a_pd)
        && o_conv_b_valid == (i_conv_b_valid && !o_adc_b_pd))
        else $error("powered-down channel still delivers results");
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_ctrl_hold: assert property (!i_wr |=> $stable(o_chip_pd) && $stable(o_int_ref_en))
        else $error("control output changed without a write");
endmodule

bind acb_reg_bank acb_reg_bank_props i_acb_reg_bank_props (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_conv_a_valid(i_conv_a_valid), .i_conv_b_valid(i_conv_b_valid), .o_conv_a_valid(o_conv_a_valid),
    .o_conv_b_valid(o_conv_b_valid), .o_adc_a_pd(o_adc_a_pd), .o_adc_b_pd(o_adc_b_pd), .o_chip_pd(o_chip_pd),
    .o_int_ref_en(o_int_ref_en), .o_sdr_mode(o_sdr_mode), .o_xor_with_lsb(o_xor_with_lsb),
    .o_oscillator_sync_mode(o_oscillator_sync_mode), .o_downconverter_enable(o_downconverter_enable),
    .o_oscillator_phase_word(o_oscillator_phase_word), .o_oscillator_frequency_word(o_oscillator_frequency_word));

// ### testbench.sv
/*
 * self-checking bench for the converter configuration register bank.
 * assumes acb_pkg compiled first and acb_consts.svh on the include path.
 */
`timescale 1ns/1ps
`include "acb_consts.svh"

module testbench
    import acb_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, va = 1'b1, vb = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wd = 16'h0000, rdata;
    logic ava, bva, apd, bpd, cpd, iref, sdr, lca, lcb, lcc, hclk, avg, init, xen, xl, sync, ddc, l24;
    logic [2:0] acfg;
    logic [1:0] lcnt, lrc;
    logic [23:0] ph, fr;
    int err_total = 0;
    int checked = 0;
    logic [7:0] offs [10] = '{`ACB_OFF_LANE_AVG_PWR, `ACB_OFF_REF_RATE, `ACB_OFF_AVG_CHIP_PWR,
        `ACB_OFF_LANE_CLK_EXTRA, `ACB_OFF_STARTUP_A, `ACB_OFF_STARTUP_B, `ACB_OFF_DDC_CTRL,
        `ACB_OFF_OSC_PH_LO, `ACB_OFF_OSC_MID, `ACB_OFF_OSC_FR_HI};
    logic [2:0] lanes [4] = '{3'h0, 3'h2, 3'h5, 3'h7};
    // documented fields only, reserved bits zero, lane clock bits suit lane setting 0
    logic [15:0] vals [10] = '{16'h0783, 16'h0901, 16'h0023, 16'h000C, 16'h0002, 16'h0002, 16'h000F,
        16'hA5C3, 16'h5A3C, 16'hC35A};

    // 250 MHz core clock
    always #2 clk = ~clk;

    acb_reg_bank i_acb_reg_bank (.i_core_clk(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wd), .i_wr(wr_en),
        .i_rd(rd_en), .o_rdata(rdata), .i_conv_a_valid(va), .i_conv_b_valid(vb), .o_conv_a_valid(ava),
        .o_conv_b_valid(bva), .o_adc_a_pd(apd), .o_adc_b_pd(bpd), .o_chip_pd(cpd), .o_int_ref_en(iref),
        .o_sdr_mode(sdr), .o_averaging_output_clock_cfg(acfg), .o_lane_count(lcnt), .o_lane_24bit(l24),
        .o_lane_clock_sel_a(lca), .o_lane_clock_sel_b(lcb), .o_lane_clock_sel_c(lcc),
        .o_low_rate_variant_clock(lrc), .o_high_rate_variant_clock(hclk), .o_avg_enabled(avg),
        .o_init_active(init), .o_xor_en(xen), .o_xor_with_lsb(xl), .o_oscillator_sync_mode(sync),
        .o_downconverter_enable(ddc), .o_oscillator_phase_word(ph), .o_oscillator_frequency_word(fr));

    ////////////////////////////////////////////////////////////////////////////
    // compare, count and report
    task chk(input logic [23:0] s, input logic [23:0] e);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // one-cycle write; outputs are settled when it returns
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask

    // one-cycle read; data is only valid in the following cycle
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    task conclude;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(iref, 1'b1);
        chk(lcnt, 2'h2);
        for (int i = 0; i < 10; i++)
            rd(offs[i], 16'h0000);
        for (int i = 0; i < 10; i++)
        begin
            wr(offs[i], vals[i]);
            rd(offs[i], vals[i]);
            wr(offs[i], 16'h0000);
        end
        for (int c = 0; c < 4; c++)
        begin
            wr(`ACB_OFF_LANE_AVG_PWR, 16'(c));
            chk({apd, bpd}, {c[0], c[1]});
            chk({ava, bva}, {!c[0], !c[1]});
        end
        // one-lane 20-bit layout, so the clock bits set below are the legal ones
        wr(`ACB_OFF_LANE_CFG, 16'h0005);
        wr(`ACB_OFF_LANE_AVG_PWR, 16'h1680);
        chk(acfg, 3'h5);
        chk(lca, 1'b1);
        // a running channel passes its own strobe, not a constant
        @(posedge clk);
        {va, vb} <= 2'h1;
        #1;
        chk({ava, bva}, 2'h1);
        @(posedge clk);
        {va, vb} <= 2'h3;
        wr(`ACB_OFF_AVG_CHIP_PWR, 16'h0022);
        chk(avg, 1'b1);
        wr(`ACB_OFF_AVG_CHIP_PWR, 16'h0001);
        chk({cpd, apd, bpd, ava, bva}, 5'h1C);
        rd(`ACB_OFF_STATUS, 16'h0007);
        wr(`ACB_OFF_AVG_CHIP_PWR, 16'h0000);
        chk({cpd, avg}, 2'h0);
        wr(`ACB_OFF_REF_RATE, 16'h0901);
        chk({iref, sdr, lcb}, 3'h3);
        wr(`ACB_OFF_LANE_CLK_EXTRA, 16'h020C);
        chk({lcc, lrc}, 3'h7);
        wr(`ACB_OFF_DDC_CTRL, 16'h000F);
        chk({sync, xl, hclk, ddc}, 4'hF);
        wr(`ACB_OFF_DDC_CTRL, 16'h0005);
        chk({sync, xl, hclk, ddc}, 4'h5);
        wr(`ACB_OFF_OSC_PH_LO, 16'h1234);
        wr(`ACB_OFF_OSC_MID, 16'hABCD);
        wr(`ACB_OFF_OSC_FR_HI, 16'h5678);
        chk(ph, 24'hCD1234);
        chk(fr, 24'h5678AB);
        foreach (lanes[i])
        begin
            wr(`ACB_OFF_LANE_CFG, {12'h000, 1'b1, lanes[i]});
            chk({lcnt, l24, xen}, {(lanes[i][2] ? 2'h1 : 2'h2), lanes[i][1], 1'b1});
        end
        wr(8'h50, 16'hFFFF);
        rd(8'h50, 16'h0000);
        // startup bits are only raised inside an opened startup sequence
        wr(`ACB_OFF_STARTUP_A, 16'h0002);
        chk(init, 1'b1);
        wr(`ACB_OFF_STARTUP_A, 16'h0000);
        wr(`ACB_OFF_BANK_SEL, 16'h0001);
        wr(`ACB_OFF_B2_STARTUP_C, 16'h0040);
        rd(`ACB_OFF_B2_STARTUP_C, 16'h0040);
        chk(init, 1'b1);
        rd(`ACB_OFF_LANE_AVG_PWR, 16'h0000);
        wr(`ACB_OFF_B2_STARTUP_C, 16'h0000);
        wr(`ACB_OFF_BANK_SEL, 16'h0000);
        chk(init, 1'b0);
        conclude();
    end

    // hang guard, far beyond the roughly 160 cycles the sequence needs
    initial
    begin
        #40000;
        err_total++;
        conclude();
    end
endmodule
